//--- core/wac_core.sv
// module: wake-up ready timer, auto-calibration trigger and AXI4-Lite register slave
`default_nettype none
module wac_core (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic OSC_STABLE_IN,
  input wire logic TO_ACTIVE_IN,
  input wire logic TO_IDLE_IN,
  output logic CAL_REQ_OUT,
  output logic CHIP_READY_N_OUT,
  output logic OSC_STABLE_OUT,
  input wire logic [wac_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [wac_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);
  import wac_pkg::*;

  function automatic logic [EXP_W-1:0] expiry_target(input logic [1:0] sel);
    case (sel)
      2'h0: expiry_target = EXP_CNT_0;
      2'h1: expiry_target = EXP_CNT_1;
      2'h2: expiry_target = EXP_CNT_2;
      default: expiry_target = EXP_CNT_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wake-up timer and calibration state

  logic osc_meta_r;
  logic osc_sync_r;
  wac_wake_t wake_r, wake_nxt;
  logic [RIPPLE_W-1:0] ripple_r, ripple_nxt;
  logic [EXP_W-1:0] exp_r, exp_nxt;
  logic [1:0] ret_r, ret_nxt;
  logic cal_r, cal_nxt;
  logic ready_n_r, ready_n_nxt;
  logic stable_r, stable_nxt;
  wac_cfg_t cfg_r, cfg_nxt;

  always_comb begin
    wake_nxt = wake_r;
    ripple_nxt = ripple_r;
    exp_nxt = exp_r;
    ret_nxt = ret_r;
    cal_nxt = 1'b0;
    case (wake_r)
      WAKE_OFF: begin
        ripple_nxt = '0;
        exp_nxt = '0;
        if (osc_sync_r) begin
          wake_nxt = WAKE_COUNT;
        end
      end
      WAKE_COUNT: begin
        ripple_nxt = ripple_r + 6'h01;
        if (ripple_r == RIPPLE_LAST) begin
          exp_nxt = exp_r + 9'h001;
        end
        // compare with >= so a smaller timeout written mid-count still ends the wait
        if (exp_nxt >= expiry_target(cfg_r.power_on_timeout_select)) begin
          wake_nxt = WAKE_READY;
        end
      end
      WAKE_READY: begin
        wake_nxt = WAKE_READY;
      end
      default: begin
        wake_nxt = WAKE_OFF;
      end
    endcase
    // losing the oscillator restarts the whole wait from zero
    if (!osc_sync_r) begin
      wake_nxt = WAKE_OFF;
      ripple_nxt = '0;
      exp_nxt = '0;
    end
    ready_n_nxt = (wake_nxt != WAKE_READY);
    stable_nxt = (wake_nxt == WAKE_READY);

    case (cfg_r.synth_auto_calibration_select)
      AUTOCAL_TO_ACTIVE: begin
        cal_nxt = TO_ACTIVE_IN;
      end
      AUTOCAL_TO_IDLE: begin
        cal_nxt = TO_IDLE_IN;
      end
      AUTOCAL_FOURTH_IDLE: begin
        if (TO_IDLE_IN) begin
          ret_nxt = ret_r + 2'h1;
          cal_nxt = (ret_r == RET_LAST);
        end
      end
      default: begin
        cal_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      wake_r <= WAKE_OFF;
      ripple_r <= '0;
      exp_r <= '0;
      ret_r <= '0;
      cal_r <= 1'b0;
      ready_n_r <= 1'b1;
      stable_r <= 1'b0;
    end else if (CE_IN) begin
      osc_meta_r <= OSC_STABLE_IN;
      osc_sync_r <= osc_meta_r;
      wake_r <= wake_nxt;
      ripple_r <= ripple_nxt;
      exp_r <= exp_nxt;
      ret_r <= ret_nxt;
      cal_r <= cal_nxt;
      ready_n_r <= ready_n_nxt;
      stable_r <= stable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic aw_held_r, aw_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_strb0_r, w_strb0_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[STAT_READY_BIT] = ~ready_n_r;
    status_word[STAT_STABLE_BIT] = stable_r;
    status_word[STAT_EXP_LSB +: EXP_W] = exp_r;
    status_word[STAT_RET_LSB +: 2] = ret_r;

    cfg_nxt = cfg_r;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb0_nxt = w_strb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;

    if (S_AXI_AWVALID_IN && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA_IN;
      w_strb0_nxt = S_AXI_WSTRB_IN[0];
    end
    if (bvalid_r && S_AXI_BREADY_IN) begin
      bvalid_nxt = 1'b0;
    end
    // commit one cycle after both halves are held; keeps the decode off the input path
    if (aw_held_r && w_held_r && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (aw_addr_r == ADDR_CONFIG) begin
        if (w_strb0_r) begin
          cfg_nxt = w_data_r[7:0];
          cfg_nxt.unused = 2'h0;
        end
      end else if (aw_addr_r != ADDR_STATUS) begin
        bresp_nxt = RESP_SLVERR;
      end
    end

    if (rvalid_r && S_AXI_RREADY_IN) begin
      rvalid_nxt = 1'b0;
    end
    if (S_AXI_ARVALID_IN && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      if (S_AXI_ARADDR_IN == ADDR_CONFIG) begin
        rdata_nxt = {24'h000000, cfg_r};
      end else if (S_AXI_ARADDR_IN == ADDR_STATUS) begin
        rdata_nxt = status_word;
      end else begin
        rdata_nxt = '0;
        rresp_nxt = RESP_SLVERR;
      end
    end

    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_r <= CFG_RESET;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (CE_IN) begin
      cfg_r <= cfg_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb0_r <= w_strb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign CAL_REQ_OUT = cal_r;
  assign CHIP_READY_N_OUT = ready_n_r;
  assign OSC_STABLE_OUT = stable_r;
  assign S_AXI_AWREADY_OUT = awready_r;
  assign S_AXI_WREADY_OUT = wready_r;
  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT = bresp_r;
  assign S_AXI_ARREADY_OUT = arready_r;
  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RDATA_OUT = rdata_r;
  assign S_AXI_RRESP_OUT = rresp_r;

endmodule // wac_core
`default_nettype wire

//--- core/wac_pkg.sv
// package: constants, register layout and types for the wake-up ready and auto-calibration block
// Summary of operation
// - a two-bit field picks when the synthesizer calibrates on idle/active moves
// - at setting 3 calibrate only on every fourth return to idle
// - after oscillator is stable, wait programmed ripple expiries, then drive ready low
// - timeout field picks 1, 16, 64 or 256 expiries; resets to 16
// - oscillator-stable output rises together with chip ready
`default_nettype none
package wac_pkg;

  localparam int ADDR_W = 8;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

  // auto-calibration settings
  localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
  localparam logic [1:0] AUTOCAL_TO_ACTIVE = 2'h1;
  localparam logic [1:0] AUTOCAL_TO_IDLE = 2'h2;
  localparam logic [1:0] AUTOCAL_FOURTH_IDLE = 2'h3;

  // configuration register, bits 7:6 read as zero
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] synth_auto_calibration_select;
    logic [1:0] power_on_timeout_select;
    logic pin_control_enable;
    logic oscillator_keep_on_in_sleep;
  } wac_cfg_t;

  localparam wac_cfg_t CFG_RESET = 8'h04;

  // status register field positions
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_STABLE_BIT = 1;
  localparam int STAT_EXP_LSB = 8;
  localparam int STAT_RET_LSB = 20;

  // ripple counter and expiry counts
  localparam int RIPPLE_W = 6;
  localparam logic [RIPPLE_W-1:0] RIPPLE_LAST = 6'h3F;
  localparam int EXP_W = 9;
  localparam logic [EXP_W-1:0] EXP_CNT_0 = 9'h001;
  localparam logic [EXP_W-1:0] EXP_CNT_1 = 9'h010;
  localparam logic [EXP_W-1:0] EXP_CNT_2 = 9'h040;
  localparam logic [EXP_W-1:0] EXP_CNT_3 = 9'h100;
  localparam logic [1:0] RET_LAST = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WAKE_OFF, WAKE_COUNT, WAKE_READY} wac_wake_t;

endpackage : wac_pkg
`default_nettype wire

//--- tb/wac_chk.sv
// checker: port-level properties of the wake-up and calibration block
`default_nettype none
module wac_chk (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic OSC_STABLE_IN,
  input wire logic TO_ACTIVE_IN,
  input wire logic TO_IDLE_IN,
  input wire logic CAL_REQ_OUT,
  input wire logic CHIP_READY_N_OUT,
  input wire logic OSC_STABLE_OUT,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  // a frozen clock enable stalls every counter, so cycle counts mean nothing then
  default disable iff (RST_IN || !CE_IN);
  sequence s_osc_off;
    $fell(OSC_STABLE_IN);
  endsequence
  property p_same; OSC_STABLE_OUT == !CHIP_READY_N_OUT; endproperty
  property p_late; $fell(CHIP_READY_N_OUT) |-> $past(OSC_STABLE_IN, 64); endproperty
  property p_drop; s_osc_off |-> ##[1:4] CHIP_READY_N_OUT; endproperty
  // the pin is low for two samples, so only the first synchroniser stage has taken the loss; its output can still be high
  property p_hold;
    CHIP_READY_N_OUT && !OSC_STABLE_IN && !$past(OSC_STABLE_IN) |=> CHIP_READY_N_OUT;
  endproperty
  property p_cause; CAL_REQ_OUT |-> $past(TO_ACTIVE_IN) || $past(TO_IDLE_IN); endproperty
  property p_one; CAL_REQ_OUT |=> !CAL_REQ_OUT; endproperty
  property p_bresp; $rose(S_AXI_BVALID_OUT) |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT;
  endproperty
  property p_rresp; S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT; endproperty
  a_same: assert property (p_same) else $error("stable and ready disagree");
  a_late: assert property (p_late) else $error("ready before one expiry");
  a_drop: assert property (p_drop) else $error("ready kept after osc loss");
  a_hold: assert property (p_hold) else $error("ready without osc");
  a_cause: assert property (p_cause) else $error("calibration without event");
  a_one: assert property (p_one) else $error("calibration pulse too long");
  a_bresp: assert property (p_bresp) else $error("write ready during response");
  a_rresp: assert property (p_rresp) else $error("read ready during response");
endmodule // wac_chk
bind wac_core wac_chk chk (
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_IN(RST_IN),
  .CE_IN(CE_IN),
  .OSC_STABLE_IN(OSC_STABLE_IN),
  .TO_ACTIVE_IN(TO_ACTIVE_IN),
  .TO_IDLE_IN(TO_IDLE_IN),
  .CAL_REQ_OUT(CAL_REQ_OUT),
  .CHIP_READY_N_OUT(CHIP_READY_N_OUT),
  .OSC_STABLE_OUT(OSC_STABLE_OUT),
  .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
  .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT)
);
`default_nettype wire

//--- tb/wac_core_tb.sv
// testbench: register access, wake-up timeout and calibration modes
`default_nettype none
module wac_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wac_pkg::*;
  logic clk = 0, rst = 1, pwr = 0, act = 0, idl = 0, awv = 0, wv = 0, bq = 0, arv = 0, rq = 0;
  logic [7:0] aa = 0, ra = 0;
  logic [3:0] ws = 4'hF;
  logic [31:0] wd = 0, fails = 0, total_checks = 0, cal_n = 0, c0, wt, rd;
  logic cal, rdy_n, stab, osc, awr, wr, bv, arr, rv;
  logic [1:0] br, rr;
  int ex[4] = '{1, 16, 64, 256};
  logic [31:0] calx[4] = '{32'h0, 32'h1, 32'h4, 32'h1};
  always #10 clk = ~clk;
  always @(posedge clk) if (cal === 1'b1) cal_n <= cal_n + 32'h1;
  wac_host host (.clk_in(clk), .power_in(pwr), .ready_n_in(rdy_n), .osc_out(osc), .wait_out(wt));
  wac_core dut (.CORE_CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .OSC_STABLE_IN(osc),
    .TO_ACTIVE_IN(act), .TO_IDLE_IN(idl), .CAL_REQ_OUT(cal), .CHIP_READY_N_OUT(rdy_n),
    .OSC_STABLE_OUT(stab), .S_AXI_AWADDR_IN(aa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(br),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bq), .S_AXI_ARADDR_IN(ra),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd),
    .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rq));
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    aa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bq <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    bq <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, br});
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rq <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rq <= 1'b0;
    cmp("rdata", e, rd);
    cmp("rresp", {30'h0, er}, {30'h0, rr});
  endtask
  task automatic pulse(input logic i);
    @(posedge clk);
    idl <= i;
    act <= !i;
    @(posedge clk);
    idl <= 1'b0;
    act <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude;
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(ADDR_CONFIG, 32'h4, RESP_OKAY);
    axr(8'h0C, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0, RESP_OKAY);
    axw(8'h0C, 32'h0, RESP_SLVERR);
    // timeout 2 and 3 are what a host picks for a stopped or running oscillator
    for (int t = 0; t < 4; t++) begin
      axw(ADDR_CONFIG, 32'(t * 4), RESP_OKAY);
      pwr <= 1'b1;
      for (int n = 0; n < 17000 && rdy_n !== 1'b0; n++) @(posedge clk);
      cmp("wake", 32'h1, {31'h0, wt >= 64 * ex[t] && wt <= 64 * ex[t] + 10});
      cmp("stable", 32'h1, {31'h0, stab});
      axr(ADDR_STATUS, 32'h3 | (32'(ex[t]) << STAT_EXP_LSB), RESP_OKAY);
      pwr <= 1'b0;
      repeat (6) @(posedge clk);
      cmp("restart", 32'h1, {31'h0, rdy_n});
    end
    // mode 3 first enters here with its return counter still at zero
    for (int m = 0; m < 4; m++) begin
      axw(ADDR_CONFIG, 32'(m * 16 + 4), RESP_OKAY);
      c0 = cal_n;
      pulse(1'b0);
      repeat (4) pulse(1'b1);
      cmp("cal", calx[m], cal_n - c0);
    end
    // still in mode 3 with a wrapped counter: one more return leaves it at one
    pulse(1'b1);
    axr(ADDR_STATUS, 32'h1 << STAT_RET_LSB, RESP_OKAY);
    axw(ADDR_CONFIG, 32'hFF, RESP_OKAY);
    // a write without the low byte lane enabled must leave the configuration alone
    ws <= 4'h0;
    axw(ADDR_CONFIG, 32'h00, RESP_OKAY);
    ws <= 4'hF;
    axr(ADDR_CONFIG, 32'h3F, RESP_OKAY);
    conclude;
  end
  initial begin
    #1000000;
    fails++;
    conclude;
  end
endmodule // wac_core_tb
`default_nettype wire

//--- tb/wac_host.sv
// partner: oscillator start-up and host timing of the ready indication
`default_nettype none
module wac_host (
  input wire logic clk_in,
  input wire logic power_in,
  input wire logic ready_n_in,
  output logic osc_out,
  output logic [31:0] wait_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // oscillator settles one cycle after power; host counts cycles until ready
  always @(posedge clk_in) begin
    osc_out <= power_in;
    if (!power_in) wait_out <= 32'h0;
    else if (ready_n_in) wait_out <= wait_out + 32'h1;
  end
endmodule // wac_host
`default_nettype wire
